/* File: core/cie_defs.vh */
// constants for the instruction execution subset
`ifndef CIE_DEFS_VH
`define CIE_DEFS_VH

// register offsets
`define CIE_FLAGS_ADDR 8'hd5
`define CIE_WPL_ADDR   8'hd6
`define CIE_WPH_ADDR   8'hd7

// reset values
`define CIE_FLAGS_RST  8'h00
`define CIE_WPL_RST    8'h00
`define CIE_WPH_RST    8'h08

// flag bit positions
`define CIE_F_C    7
`define CIE_F_Z    6
`define CIE_F_S    5
`define CIE_F_V    4
`define CIE_F_D    3
`define CIE_F_H    2
`define CIE_F_BANK 0

// opcodes
`define CIE_OP_RRC_IR  8'hc1
`define CIE_OP_BANK0   8'h4f
`define CIE_OP_BANK1   8'h5f
`define CIE_OP_CF1     8'hdf
`define CIE_OP_ASR_R   8'hd0
`define CIE_OP_ASR_IR  8'hd1
`define CIE_OP_PTRLD   8'h31
`define CIE_OP_STOP    8'h7f
`define CIE_OP_SWAP_R  8'hf0
`define CIE_OP_SWAP_IR 8'hf1
`define CIE_HI_SUB     4'h2
`define CIE_HI_SBC     4'h3

// timing in cycles
`define CIE_CYC_SHORT  3'd4
`define CIE_CYC_LONG   3'd6

`endif

/* File: core/cie_exec.v */
// execution logic for a run of instructions of an 8-bit cpu core
//
// Function
// [RULE1] rotate right through carry, indirect, opcode c1
// [RULE2] opcode 4f clears bank flag only
// [RULE3] opcode 5f sets bank flag only
// [RULE4] subtract with borrow, opcodes 32 to 36
// [RULE5] borrow sets carry; zero, sign, overflow flags
// [RULE6] borrow subtract sets decimal flag, half borrow
// [RULE7] opcode df forces carry, four cycles
// [RULE8] arithmetic shift right keeps sign, d0/d1
// [RULE9] shift flags: carry, zero, sign, overflow cleared
// [RULE10] pointer load: 10 low, 01 high pointer
// [RULE11] pointer load 00: both pointers, bit3 forced
// [RULE12] stop halts clocks and keeps all registers
// [RULE13] stop left on reset or external interrupt
// [RULE14] reset held low until oscillator settles
// [RULE15] stream puts three no-ops after stop
// [RULE16] plain subtract, opcodes 22 to 26
// [RULE17] plain subtract flag updates
// [RULE18] nibble exchange f0/f1 with flags
// [RULE19] undefined flags keep previous value
// [RULE20] register forms 4 cycles, others 6; here only subtract forms other than r,r take 6, indirect d1/c1/f1 take 4
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "cie_defs.vh"

module cie_exec (
    input  wire       clk_sys,
    input  wire       resetn,
    input  wire       instr_valid,
    input  wire [7:0] instr_opcode,
    input  wire [7:0] instr_byte1,
    input  wire [7:0] instr_byte2,
    output wire       instr_ready,
    input  wire       ext_int_pin,
    output wire       stop_state,
    output wire       cpu_clk_en,
    output wire [7:0] flags_out,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output wire [7:0] reg_rdata
);

////////////////////////////////////////////////////////////////////////////////
// state

    reg [7:0] mem [0:255];
    reg [7:0] flags_reg;
    reg [7:0] flags_next;
    reg [7:0] wpl_reg;
    reg [7:0] wpl_next;
    reg [7:0] wph_reg;
    reg [7:0] wph_next;
    reg       stop_reg;
    reg       stop_next;
    reg       clk_en_reg;
    reg       ready_reg;
    reg [2:0] busy_reg;
    reg [2:0] busy_next;
    reg [7:0] rdata_reg;
    reg       int_s1_reg;
    reg       int_s2_reg;

    // execution datapath
    reg [7:0] dst_a;
    reg [7:0] dst_v;
    reg [7:0] src_v;
    reg [7:0] res;
    reg       wr_en;
    reg [2:0] cyc;
    reg [8:0] sum9;
    reg [4:0] sum5;
    reg       cin;

    // an instruction is taken only on an edge with ready high
    wire      take = instr_valid & ready_reg;

////////////////////////////////////////////////////////////////////////////////
// helpers

    // one register read, system registers decoded ahead of the file
    function [7:0] rd;
        input [7:0] a;
        begin
            if (a == `CIE_FLAGS_ADDR)
                rd = flags_reg;
            else if (a == `CIE_WPL_ADDR)
                rd = wpl_reg;
            else if (a == `CIE_WPH_ADDR)
                rd = wph_reg;
            else
                rd = mem[a];
        end
    endfunction

    // working register number to file address via the pointers
    function [7:0] wa;
        input [3:0] n;
        begin
            if (n[3])
                wa = {wph_reg[7:3], n[2:0]};
            else
                wa = {wpl_reg[7:3], n[2:0]};
        end
    endfunction

////////////////////////////////////////////////////////////////////////////////
// operand fetch and execute

    // all operands resolve in the accept cycle; the rest is wait time
    // file reads inside rd are not in the event list; the take edge retriggers it
    always @*
    begin
        dst_a      = instr_byte1;
        dst_v      = 8'h00;
        src_v      = 8'h00;
        res        = 8'h00;
        wr_en      = 1'b0;
        cyc        = `CIE_CYC_SHORT;
        sum9       = 9'h000;
        sum5       = 5'h00;
        cin        = 1'b1;
        flags_next = flags_reg;
        wpl_next   = wpl_reg;
        wph_next   = wph_reg;
        stop_next  = stop_reg;
        if (take)
        begin
            case (instr_opcode[7:4])
                `CIE_HI_SUB, `CIE_HI_SBC:
                begin
                    // addressing forms by low nibble
                    case (instr_opcode[3:0])
                        4'h2:
                        begin
                            dst_a = wa(instr_byte1[7:4]);
                            src_v = rd(wa(instr_byte1[3:0]));
                        end
                        4'h3:
                        begin
                            dst_a = wa(instr_byte1[7:4]);
                            src_v = rd(rd(wa(instr_byte1[3:0])));
                        end
                        4'h4:
                        begin
                            dst_a = instr_byte2;
                            src_v = rd(instr_byte1);
                        end
                        4'h5:
                        begin
                            dst_a = instr_byte2;
                            src_v = rd(rd(instr_byte1));
                        end
                        default:
                        begin
                            dst_a = instr_byte1;
                            src_v = instr_byte2;
                        end
                    endcase
                end
                default:
                begin
                    // single operand: even opcode direct, odd indirect
                    if (instr_opcode[0])
                        dst_a = rd(instr_byte1);
                    else
                        dst_a = instr_byte1;
                end
            endcase
            dst_v = rd(dst_a);

            if ((instr_opcode[7:4] == `CIE_HI_SUB || instr_opcode[7:4] == `CIE_HI_SBC)
                && instr_opcode[3:0] >= 4'h2 && instr_opcode[3:0] <= 4'h6)
            begin
                // subtract as add of the complement; borrow folds into cin
                if (instr_opcode[7:4] == `CIE_HI_SBC)
                    cin = ~flags_reg[`CIE_F_C];              // [RULE4]
                sum9 = {1'b0, dst_v} + {1'b0, ~src_v} + {8'h00, cin}; // [RULE4] [RULE16]
                sum5 = {1'b0, dst_v[3:0]} + {1'b0, ~src_v[3:0]} + {4'h0, cin};
                res  = sum9[7:0];
                wr_en = 1'b1;
                flags_next[`CIE_F_C] = ~sum9[8];                 // [RULE5] [RULE17]
                flags_next[`CIE_F_Z] = (res == 8'h00);           // [RULE5] [RULE17]
                flags_next[`CIE_F_S] = res[7];                   // [RULE5] [RULE17]
                flags_next[`CIE_F_V] = (dst_v[7] != src_v[7]) &&
                                       (res[7] == src_v[7]);     // [RULE5] [RULE17]
                flags_next[`CIE_F_D] = 1'b1;                     // [RULE6] [RULE17]
                flags_next[`CIE_F_H] = ~sum5[4];                 // [RULE6] [RULE17]
                if (instr_opcode[3:0] != 4'h2)
                    cyc = `CIE_CYC_LONG;                         // [RULE20]
            end
            else
            begin
                case (instr_opcode)
                    `CIE_OP_RRC_IR:
                    begin
                        res   = {flags_reg[`CIE_F_C], dst_v[7:1]};  // [RULE1]
                        wr_en = 1'b1;
                        flags_next[`CIE_F_C] = dst_v[0];             // [RULE1]
                        flags_next[`CIE_F_Z] = (res == 8'h00);
                        flags_next[`CIE_F_S] = res[7];
                        flags_next[`CIE_F_V] = res[7] ^ dst_v[7];
                    end
                    `CIE_OP_BANK0:
                        flags_next[`CIE_F_BANK] = 1'b0;              // [RULE2]
                    `CIE_OP_BANK1:
                        flags_next[`CIE_F_BANK] = 1'b1;              // [RULE3]
                    `CIE_OP_CF1:
                        flags_next[`CIE_F_C] = 1'b1;                 // [RULE7]
                    `CIE_OP_ASR_R, `CIE_OP_ASR_IR:
                    begin
                        res   = {dst_v[7], dst_v[7:1]};              // [RULE8]
                        wr_en = 1'b1;
                        flags_next[`CIE_F_C] = dst_v[0];             // [RULE9]
                        flags_next[`CIE_F_Z] = (res == 8'h00);       // [RULE9]
                        flags_next[`CIE_F_S] = res[7];               // [RULE9]
                        flags_next[`CIE_F_V] = 1'b0;                 // [RULE9]
                    end
                    `CIE_OP_PTRLD:
                    begin
                        // a code of 11 in the low bits changes nothing
                        case (instr_byte1[1:0])
                            2'b10:
                                wpl_next[7:3] = instr_byte1[7:3];    // [RULE10]
                            2'b01:
                                wph_next[7:3] = instr_byte1[7:3];    // [RULE10]
                            2'b00:
                            begin
                                wpl_next[7:3] = {instr_byte1[7:4], 1'b0}; // [RULE11]
                                wph_next[7:3] = {instr_byte1[7:4], 1'b1}; // [RULE11]
                            end
                            default:
                                wpl_next = wpl_reg;
                        endcase
                    end
                    `CIE_OP_STOP:
                        stop_next = 1'b1;                            // [RULE12]
                    `CIE_OP_SWAP_R, `CIE_OP_SWAP_IR:
                    begin
                        res   = {dst_v[3:0], dst_v[7:4]};            // [RULE18]
                        wr_en = 1'b1;
                        // carry and overflow simply hold
                        flags_next[`CIE_F_Z] = (res == 8'h00);       // [RULE18] [RULE19]
                        flags_next[`CIE_F_S] = res[7];               // [RULE18]
                    end
                    default:
                        wr_en = 1'b0;
                endcase
            end
        end
        // wake from stop on a synchronised interrupt level
        if (stop_reg && int_s2_reg)
            stop_next = 1'b0;                                        // [RULE13]
    end

////////////////////////////////////////////////////////////////////////////////
// register file, written by software then by execution

    // no reset here: the file keeps its contents through stop
    always @(posedge clk_sys)
    begin
        if (reg_wr && reg_addr != `CIE_FLAGS_ADDR && reg_addr != `CIE_WPL_ADDR
            && reg_addr != `CIE_WPH_ADDR)
            mem[reg_addr] <= reg_wdata;
        if (wr_en && dst_a != `CIE_FLAGS_ADDR && dst_a != `CIE_WPL_ADDR
            && dst_a != `CIE_WPH_ADDR)
            mem[dst_a] <= res;                                       // [RULE12]
    end

////////////////////////////////////////////////////////////////////////////////
// system registers, sequencing and bus read

    // a result written to a system register beats the flag update
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            flags_reg  <= `CIE_FLAGS_RST;
            wpl_reg    <= `CIE_WPL_RST;
            wph_reg    <= `CIE_WPH_RST;
            stop_reg   <= 1'b0;                                      // [RULE13]
            clk_en_reg <= 1'b1;
            ready_reg  <= 1'b0;
            busy_reg   <= 3'd0;
            rdata_reg  <= 8'h00;
            int_s1_reg <= 1'b0;
            int_s2_reg <= 1'b0;
        end
        else
        begin
            // wake pin crosses in through two flops
            int_s1_reg <= ext_int_pin;
            int_s2_reg <= int_s1_reg;
            flags_reg  <= flags_next;
            wpl_reg    <= wpl_next;
            wph_reg    <= wph_next;
            if (reg_wr && reg_addr == `CIE_FLAGS_ADDR)
                flags_reg <= reg_wdata;
            if (reg_wr && reg_addr == `CIE_WPL_ADDR)
                wpl_reg <= reg_wdata;
            if (reg_wr && reg_addr == `CIE_WPH_ADDR)
                wph_reg <= reg_wdata;
            if (wr_en && dst_a == `CIE_FLAGS_ADDR)
                flags_reg <= res;
            if (wr_en && dst_a == `CIE_WPL_ADDR)
                wpl_reg <= res;
            if (wr_en && dst_a == `CIE_WPH_ADDR)
                wph_reg <= res;
            stop_reg <= stop_next;
            // own flop for the enable so the pin never sees gate logic
            clk_en_reg <= ~stop_next;                                // [RULE12]
            busy_reg <= busy_next;
            // no instruction is taken while busy or stopped
            ready_reg <= (busy_next == 3'd0) && !stop_next;          // [RULE12]
            if (reg_rd)
                rdata_reg <= rd(reg_addr);
            else
                rdata_reg <= 8'h00;
        end
    end

    // wait count so each instruction spans its cycle figure
    always @*
    begin
        if (take)
            busy_next = cyc - 3'd1;                                  // [RULE7] [RULE20]
        else if (busy_reg != 3'd0)
            busy_next = busy_reg - 3'd1;
        else
            busy_next = 3'd0;
    end

    assign instr_ready = ready_reg;
    assign stop_state  = stop_reg;
    assign cpu_clk_en  = clk_en_reg;
    assign flags_out   = flags_reg;
    assign reg_rdata   = rdata_reg;

endmodule // cie_exec

/* File: sim/cie_exec_assertions.sv */
// concurrent checks on the ports of the instruction execution block
`timescale 1ns/1ps
`include "cie_defs.vh"

module cie_exec_chk (
    input logic       clk_sys,
    input logic       resetn,
    input logic       instr_valid,
    input logic [7:0] instr_opcode,
    input logic       instr_ready,
    input logic       ext_int_pin,
    input logic       stop_state,
    input logic       cpu_clk_en,
    input logic [7:0] flags_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // take strobe and opcode classes; subtract forms other than r,r are the slow ones
    wire       tk  = instr_valid && instr_ready;
    wire [3:0] hi  = instr_opcode[7:4];
    wire [3:0] lo  = instr_opcode[3:0];
    wire       sub = (hi == 4'h2 || hi == 4'h3) && lo >= 4'h2 && lo <= 4'h6;
    wire       lng = sub && lo != 4'h2;
    wire       stp = instr_opcode == `CIE_OP_STOP;

    ////////////////////////////////////////////////////////////////////////////////
    property p_cyc_short; tk && !lng && !stp |=> !instr_ready [*3] ##1 instr_ready; endproperty
    a_cyc_short: assert property (p_cyc_short)
        else $error("short instruction busy time wrong");
    property p_cyc_long; tk && lng |=> !instr_ready [*5] ##1 instr_ready; endproperty
    a_cyc_long: assert property (p_cyc_long)
        else $error("long instruction busy time wrong");
    property p_stop_in; tk && stp |=> stop_state && !cpu_clk_en && !instr_ready; endproperty
    a_stop_in: assert property (p_stop_in)
        else $error("stop not entered");
    // quiet wake pin over the whole sync depth means stop must hold
    property p_stop_hold;
        stop_state && !ext_int_pin && !$past(ext_int_pin) && !$past(ext_int_pin, 2)
            && !$past(ext_int_pin, 3) |=> stop_state;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stop left without cause");
    property p_wake; $rose(ext_int_pin) && stop_state |-> ##[1:5] !stop_state; endproperty
    a_wake: assert property (p_wake)
        else $error("interrupt did not end stop");
    property p_bank;
        tk && (instr_opcode == `CIE_OP_BANK0 || instr_opcode == `CIE_OP_BANK1)
            |=> flags_out[0] == $past(instr_opcode[4]) && flags_out[7:1] == $past(flags_out[7:1]);
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank select flags wrong");
    property p_cf1; tk && instr_opcode == `CIE_OP_CF1 |=> flags_out == ($past(flags_out) | 8'h80);
    endproperty
    a_cf1: assert property (p_cf1)
        else $error("carry force flags wrong");
    property p_asr;
        tk && (instr_opcode == `CIE_OP_ASR_R || instr_opcode == `CIE_OP_ASR_IR)
            |=> !flags_out[`CIE_F_V] && flags_out[3:2] == $past(flags_out[3:2]);
    endproperty
    a_asr: assert property (p_asr)
        else $error("shift flags wrong");

    // main scenarios reached
    c_long: cover property (tk && lng);
    c_stop: cover property (tk && stp);
    c_wake: cover property ($fell(stop_state));
endmodule // cie_exec_chk

bind cie_exec cie_exec_chk chk_u (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .instr_ready(instr_ready), .ext_int_pin(ext_int_pin),
    .stop_state(stop_state), .cpu_clk_en(cpu_clk_en), .flags_out(flags_out));

/* File: sim/cie_pmem.sv */
// program memory model feeding the instruction port
`timescale 1ns/1ps
`include "cie_defs.vh"

module cie_pmem #(parameter logic [7:0] NOP_OP = 8'hff) (
    input  logic       clk_sys,
    input  logic       instr_ready,
    output logic       instr_valid,
    output logic [7:0] instr_opcode,
    output logic [7:0] instr_byte1,
    output logic [7:0] instr_byte2
);
    // idle bus at time zero
    initial
    begin
        instr_valid  = 1'b0;
        instr_opcode = 8'h00;
        instr_byte1  = 8'h00;
        instr_byte2  = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // hold one instruction until taken; idle lines inverted so stale bytes never match
    task issue(input logic [7:0] op, b1, b2);
        @(negedge clk_sys);
        while (instr_ready !== 1'b1)
            @(negedge clk_sys);
        @(posedge clk_sys);
        instr_valid  <= 1'b1;
        instr_opcode <= op;
        instr_byte1  <= b1;
        instr_byte2  <= b2;
        @(posedge clk_sys);
        instr_valid  <= 1'b0;
        instr_opcode <= ~op;
        instr_byte1  <= ~b1;
        instr_byte2  <= ~b2;
    endtask

    // stop is always trailed by settling no-ops
    task run_stop;
        issue(`CIE_OP_STOP, 8'h00, 8'h00);
        repeat (3) issue(NOP_OP, 8'h00, 8'h00);
    endtask
endmodule // cie_pmem

/* File: sim/tb.sv */
// self-checking bench for the instruction execution block
`timescale 1ns/1ps
`include "cie_defs.vh"

module tb;
    localparam int         STAB = 16; // stand-in for the oscillator settle time
    localparam logic [7:0] DV [10] = '{8'h12, 8'h21, 8'h21, 8'h21, 8'h00,
                                       8'h10, 8'h20, 8'h00, 8'h80, 8'h20};
    localparam logic [7:0] SV [10] = '{8'h03, 8'h21, 8'h90, 8'h65, 8'h01,
                                       8'h03, 8'h03, 8'h00, 8'h01, 8'h8a};
    logic       clk_sys = 1'b0;
    logic       resetn = 1'b0;
    logic       ext_int_pin = 1'b0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       instr_valid, instr_ready, stop_state, cpu_clk_en;
    logic [7:0] instr_opcode, instr_byte1, instr_byte2, flags_out, reg_rdata;
    int         err_count = 0;
    int         tests_run = 0;
    int         cyc = 0;

    cie_exec dut_u (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
        .instr_opcode(instr_opcode), .instr_byte1(instr_byte1), .instr_byte2(instr_byte2),
        .instr_ready(instr_ready), .ext_int_pin(ext_int_pin), .stop_state(stop_state),
        .cpu_clk_en(cpu_clk_en), .flags_out(flags_out), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    cie_pmem pm_u (.clk_sys(clk_sys), .instr_ready(instr_ready), .instr_valid(instr_valid),
        .instr_opcode(instr_opcode), .instr_byte1(instr_byte1), .instr_byte2(instr_byte2));

    // 100 mhz clock
    always #5 clk_sys = ~clk_sys;

    // hang guard, well above the whole sequence
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            err_count = err_count + 1;
            end_sim;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk8(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task bus_wr(input logic [7:0] a, d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task chkr(input logic [7:0] a, e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk8($sformatf("reg %h", a), e, reg_rdata);
        @(negedge clk_sys);
        chk8("rdata idle", 8'h00, reg_rdata);
    endtask

    task ex(input logic [7:0] op, b1, b2);
        pm_u.issue(op, b1, b2);
        @(negedge clk_sys);
    endtask

    // reference subtract: returns result and new flags
    function automatic logic [15:0] sub_exp(input logic [7:0] d, s, f, input logic subtract_with_borrow);
        logic       cin;
        logic [8:0] sum;
        logic [4:0] lo;
        cin = subtract_with_borrow ? !f[`CIE_F_C] : 1'b1;
        sum = {1'b0, d} + {1'b0, ~s} + 9'(cin);
        lo = {1'b0, d[3:0]} + {1'b0, ~s[3:0]} + 5'(cin);
        return {sum[7:0], !sum[8], (sum[7:0] == 8'h00), sum[7],
                (d[7] != s[7] && sum[7] == s[7]), 1'b1, !lo[4], f[1:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // every subtract form once, incoming carry set on alternate passes
    task t_sub;
        logic [7:0]  op, b1, b2;
        logic [15:0] x;
        for (int i = 0; i < 10; i++)
        begin
            op = {i < 5 ? 4'h2 : 4'h3, 4'h2 + 4'(i % 5)};
            b1 = op[3:0] < 4'h4 ? 8'h12 : (op[3:0] == 4'h6 ? 8'h01 : 8'h02);
            b2 = op[3:0] == 4'h6 ? SV[i] : (op[3:0] > 4'h3 ? 8'h01 : 8'h00);
            bus_wr(8'h01, DV[i]);
            bus_wr(8'h02, op[0] ? 8'h03 : SV[i]);
            bus_wr(8'h03, SV[i]);
            bus_wr(`CIE_FLAGS_ADDR, i[0] ? 8'h81 : 8'h02);
            x = sub_exp(DV[i], SV[i], i[0] ? 8'h81 : 8'h02, op[4]);
            ex(op, b1, b2);
            chk8("flags", x[7:0], flags_out);
            chkr(8'h01, x[15:8]);
            chkr(op[0] ? 8'h03 : 8'h02, SV[i]);
        end
    endtask

    // one-operand op: even opcode direct at 00, odd opcode through 02 to 03
    task op1(input logic [7:0] f, op, v, er, ef);
        bus_wr(8'h02, 8'h03);
        bus_wr(op[0] ? 8'h03 : 8'h00, v);
        bus_wr(`CIE_FLAGS_ADDR, f);
        ex(op, op[0] ? 8'h02 : 8'h00, 8'h00);
        chk8("flags", ef, flags_out);
        chkr(op[0] ? 8'h03 : 8'h00, er);
    endtask

    task t_ptr(input logic [7:0] imm, lo, hi);
        ex(`CIE_OP_PTRLD, imm, 8'h00);
        chkr(`CIE_WPL_ADDR, lo);
        chkr(`CIE_WPH_ADDR, hi);
    endtask

    // stop woken first by interrupt, then by a long reset
    task t_stop;
        bus_wr(8'h20, 8'h5a);
        fork
            pm_u.run_stop();
            begin
                repeat (4) @(negedge clk_sys);
                chk8("stop", 8'h01, {7'h00, stop_state});
                chk8("clk_en", 8'h00, {7'h00, cpu_clk_en});
                chkr(8'h20, 8'h5a);
                @(posedge clk_sys);
                ext_int_pin <= 1'b1;
                repeat (6) @(posedge clk_sys);
                ext_int_pin <= 1'b0;
                @(negedge clk_sys);
                chk8("stop", 8'h00, {7'h00, stop_state});
            end
        join
        fork
            pm_u.run_stop();
            begin
                // reset only once stop has really been entered
                wait (stop_state === 1'b1);
                @(posedge clk_sys);
                resetn <= 1'b0;
                repeat (STAB) @(posedge clk_sys);
                resetn <= 1'b1;
                @(negedge clk_sys);
                chk8("stop", 8'h00, {7'h00, stop_state});
            end
        join
        chkr(8'h20, 8'h5a);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk8("flags", `CIE_FLAGS_RST, flags_out);
        t_ptr(8'h03, `CIE_WPL_RST, `CIE_WPH_RST);
        t_sub;
        bus_wr(`CIE_FLAGS_ADDR, 8'h7e);
        ex(`CIE_OP_CF1, 8'h00, 8'h00);
        chk8("flags", 8'hfe, flags_out);
        ex(`CIE_OP_BANK1, 8'h00, 8'h00);
        chk8("flags", 8'hff, flags_out);
        ex(`CIE_OP_BANK0, 8'h00, 8'h00);
        chk8("flags", 8'hfe, flags_out);
        op1(8'h9c, `CIE_OP_ASR_R, 8'h9a, 8'hcd, 8'h2c);
        op1(8'h9c, `CIE_OP_ASR_IR, 8'hbd, 8'hde, 8'hac);
        op1(8'h10, `CIE_OP_ASR_R, 8'h01, 8'h00, 8'hc0);
        op1(8'h0c, `CIE_OP_RRC_IR, 8'h17, 8'h0b, 8'h8c);
        op1(8'h8c, `CIE_OP_RRC_IR, 8'h0b, 8'h85, 8'hbc);
        op1(8'h9c, `CIE_OP_SWAP_R, 8'h3e, 8'he3, 8'hbc);
        op1(8'h9c, `CIE_OP_SWAP_IR, 8'ha4, 8'h4a, 8'h9c);
        op1(8'h00, `CIE_OP_SWAP_R, 8'h00, 8'h00, 8'h40);
        t_ptr(8'h4c, 8'h40, 8'h48);
        t_ptr(8'h52, 8'h50, 8'h48);
        t_ptr(8'h69, 8'h50, 8'h68);
        t_stop;
        end_sim;
    end
endmodule // tb
